//--- wwd_pkg.sv
// package: constants and types for the window watchdog supervisor
package wwd_pkg;
  // ==========================================================================
  // oscillator-period counts (both windows share one oscillator)
  // ==========================================================================
  localparam int unsigned LEAD_PERIODS = 3948;
  localparam int unsigned OPEN_PERIODS = 553;
  localparam int unsigned CLOSED_PERIODS = 527;
  localparam int unsigned CNT_W = 12;
  // ==========================================================================
  // times in their own units, and derived cycle counts at 25 MHz
  // ==========================================================================
  localparam int unsigned CLK_PERIOD_NS = 40;
  localparam int unsigned RESET_PULSE_US = 4000;
  localparam int unsigned TRIG_MIN_NS = 7000;
  localparam int unsigned RESET_PULSE_CYC = (RESET_PULSE_US * 1000) / CLK_PERIOD_NS;
  localparam int unsigned TRIG_MIN_CYC = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // fallback fault timeouts in fallback-oscillator ticks (plain defaults)
  localparam int unsigned FAULT_SHORT_TICKS = 1000;
  localparam int unsigned FAULT_OPEN_TICKS = 2000;
  // reset values
  localparam logic RST_OUT_LOW = 1'b0;
  typedef enum logic [1:0] {
    WWD_PIN_OK,
    WWD_PIN_SHORT,
    WWD_PIN_OPEN
  } wwd_pin_t;
  typedef enum logic [2:0] {
    WWD_ST_RESET,
    WWD_ST_LEAD,
    WWD_ST_CLOSED,
    WWD_ST_OPEN,
    WWD_ST_OFF
  } wwd_state_t;
endpackage : wwd_pkg

//--- wwd_trig_filter.sv
// trigger glitch filter and falling-edge detector
`timescale 1ns/1ps
`default_nettype none
module wwd_trig_filter #(
  parameter int unsigned MIN_CYC = wwd_pkg::TRIG_MIN_CYC
) (
  input wire logic clk_i,        // system clock
  input wire logic rst_n_i,      // synchronised reset, active low
  input wire logic trig_low_i,   // raw trigger, active low
  output logic fall_o            // one-cycle pulse on qualified falling edge
);
  import wwd_pkg::*;
  localparam int unsigned W = $clog2(MIN_CYC + 2);
  logic [W-1:0] low_cnt_q;
  logic filt_q;
  logic fall_q;
  // ==========================================================================
  // qualify low level only after it has held long enough
  // ==========================================================================
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_cnt_q <= '0;
    end else if (trig_low_i) begin
      low_cnt_q <= '0;
    end else if (low_cnt_q <= W'(MIN_CYC)) begin
      low_cnt_q <= low_cnt_q + W'(1);
    end
  end
  // edge reported once pulse exceeds minimum; shorter glitches vanish
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      filt_q <= 1'b1;
      fall_q <= 1'b0;
    end else begin
      fall_q <= filt_q && !trig_low_i && (low_cnt_q == W'(MIN_CYC));
      if (trig_low_i) begin
        filt_q <= 1'b1;
      end else if (low_cnt_q == W'(MIN_CYC)) begin
        filt_q <= 1'b0;
      end
    end
  end
  assign fall_o = fall_q;
endmodule : wwd_trig_filter
`default_nettype wire

//--- wwd_top.sv
// window watchdog supervisor with fail-safe fallback and undervoltage reset
//
// Contract
// - both windows counted from one oscillator
// - nominal lead, closed, open; reset 4 ms
// - bad timing pin: continual resets unless disabled
// - bad timing pin: use internal fallback oscillator
// - separate short and open fault timeouts
// - off bit applied only after two writes
// - undervoltage forces reset output low
// - first trigger within lead time, else reset
// - trigger in closed window resets at once
// - missed open window resets; trigger restarts
// - falling edge, glitches under 7 us rejected
`timescale 1ns/1ps
`default_nettype none
module wwd_top #(
  parameter int unsigned RESET_CYC = wwd_pkg::RESET_PULSE_CYC,
  parameter int unsigned LEAD_N = wwd_pkg::LEAD_PERIODS,
  parameter int unsigned CLOSED_N = wwd_pkg::CLOSED_PERIODS,
  parameter int unsigned OPEN_N = wwd_pkg::OPEN_PERIODS,
  parameter int unsigned SHORT_N = wwd_pkg::FAULT_SHORT_TICKS,
  parameter int unsigned OPEN_FAULT_N = wwd_pkg::FAULT_OPEN_TICKS
) (
  input wire logic ref_clk_i,             // 25 MHz clock
  input wire logic rst_n_i,               // async reset, active low
  input wire logic trigger_input_low_i,   // trigger from host, falling edge
  input wire logic osc_tick_i,            // one pulse per external-resistor oscillator period
  input wire logic fallback_tick_i,       // one pulse per internal fallback period
  input wire wwd_pkg::wwd_pin_t timing_resistor_pin_i, // timing pin health
  input wire logic divider_strap_pin_i,   // high at startup disables watchdog
  input wire logic cfg_frame_i,           // pulse: a configuration frame ended
  input wire logic watchdog_off_bit_i,    // off bit of that frame
  input wire logic undervolt_i,           // supply undervoltage level
  output logic reset_out_low_o,           // reset output level, active low
  output logic reset_out_low_oe_o,        // open drain: high while pulling low
  output logic wd_enabled_o               // watchdog supervising
);
  import wwd_pkg::*;
  localparam int unsigned RW = $clog2(RESET_CYC + 1);
  // ==========================================================================
  // reset synchroniser
  // ==========================================================================
  logic rs1_q, rs2_q;
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rs1_q <= 1'b0;
      rs2_q <= 1'b0;
    end else begin
      rs1_q <= 1'b1;
      rs2_q <= rs1_q;
    end
  end
  wire logic rst_n = rs2_q;

  logic trig_fall;
  wwd_trig_filter #(.MIN_CYC(TRIG_MIN_CYC)) u_filt (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n),
    .trig_low_i(trigger_input_low_i),
    .fall_o(trig_fall)
  );
  // ==========================================================================
  // timebase: fallback oscillator takes over on a bad timing pin
  // ==========================================================================
  wire logic pin_bad = (timing_resistor_pin_i != WWD_PIN_OK);
  wire logic tick = pin_bad ? fallback_tick_i : osc_tick_i;

  // ==========================================================================
  // disable: strap caught at end of startup pulse, or double off write
  // ==========================================================================
  logic strap_off_q, cfg_off_q, off_seen_q, startup_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      off_seen_q <= 1'b0;
      cfg_off_q <= 1'b0;
    end else if (cfg_frame_i) begin
      if (!watchdog_off_bit_i) begin
        off_seen_q <= 1'b0;
        cfg_off_q <= 1'b0;
      end else if (off_seen_q) begin
        cfg_off_q <= 1'b1;
      end else begin
        off_seen_q <= 1'b1;
      end
    end
  end
  // ==========================================================================
  // supervisor state machine
  // ==========================================================================
  wwd_state_t st_q;
  logic [RW-1:0] rcnt_q;
  logic [CNT_W-1:0] tcnt_q;
  logic [CNT_W-1:0] fcnt_q;
  wire logic wd_off = strap_off_q || cfg_off_q;
  wire logic rst_done = (rcnt_q == RW'(RESET_CYC - 1));

  function automatic logic [CNT_W-1:0] lim(input int unsigned n);
    lim = CNT_W'(n - 1);
  endfunction : lim

  wire logic [CNT_W-1:0] fault_lim =
    (timing_resistor_pin_i == WWD_PIN_SHORT) ? lim(SHORT_N) : lim(OPEN_FAULT_N);

  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      startup_q <= 1'b1;
      strap_off_q <= 1'b0;
    end else if (startup_q && rst_done) begin
      startup_q <= 1'b0;
      strap_off_q <= divider_strap_pin_i;
    end
  end

  // ==========================================================================
  // reset pulse counter
  // ==========================================================================
  // held at zero during undervoltage: the pulse times only once supply is back
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rcnt_q <= '0;
    end else if (st_q != WWD_ST_RESET || undervolt_i || rst_done) begin
      rcnt_q <= '0;
    end else begin
      rcnt_q <= rcnt_q + RW'(1);
    end
  end

  // ==========================================================================
  // fault timeout counter
  // ==========================================================================
  // triggers never clear it, so a bad pin keeps producing resets
  // even under a well-timed trigger stream
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      fcnt_q <= '0;
    end else if (!pin_bad || st_q == WWD_ST_RESET || st_q == WWD_ST_OFF) begin
      fcnt_q <= '0;
    end else if (tick) begin
      fcnt_q <= fcnt_q + CNT_W'(1);
    end
  end

  // ==========================================================================
  // window sequence
  // ==========================================================================
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= WWD_ST_RESET;
      tcnt_q <= '0;
    end else begin
      if (tick) begin
        tcnt_q <= tcnt_q + CNT_W'(1);
      end
      case (st_q)
        WWD_ST_RESET: begin
          tcnt_q <= '0;
          if (!undervolt_i && rst_done) begin
            st_q <= (wd_off || (startup_q && divider_strap_pin_i)) ? WWD_ST_OFF : WWD_ST_LEAD;
          end
        end
        WWD_ST_LEAD: begin
          if (trig_fall) begin
            st_q <= WWD_ST_CLOSED;
            tcnt_q <= '0;
          end else if (tick && tcnt_q == lim(LEAD_N)) begin
            st_q <= WWD_ST_RESET;
          end
        end
        WWD_ST_CLOSED: begin
          if (trig_fall) begin
            st_q <= WWD_ST_RESET;
          end else if (tick && tcnt_q == lim(CLOSED_N)) begin
            st_q <= WWD_ST_OPEN;
            tcnt_q <= '0;
          end
        end
        WWD_ST_OPEN: begin
          if (trig_fall) begin
            st_q <= WWD_ST_CLOSED;
            tcnt_q <= '0;
          end else if (tick && tcnt_q == lim(OPEN_N)) begin
            st_q <= WWD_ST_RESET;
          end
        end
        WWD_ST_OFF: begin
          tcnt_q <= '0;
          if (undervolt_i) begin
            st_q <= WWD_ST_RESET;
          end
        end
        default: begin
          st_q <= WWD_ST_RESET;
        end
      endcase
      // fault timeout overrides trigger success: resets keep coming
      if (st_q != WWD_ST_RESET && st_q != WWD_ST_OFF) begin
        if (wd_off) begin
          st_q <= WWD_ST_OFF;
        end else if (undervolt_i) begin
          st_q <= WWD_ST_RESET;
        end else if (pin_bad && tick && fcnt_q >= fault_lim) begin
          st_q <= WWD_ST_RESET;
        end
      end
    end
  end
  // ==========================================================================
  // outputs
  // ==========================================================================
  logic rst_out_q;
  always_ff @(posedge ref_clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rst_out_q <= RST_OUT_LOW;
    end else begin
      rst_out_q <= (st_q != WWD_ST_RESET) && !undervolt_i;
    end
  end
  assign reset_out_low_o = rst_out_q;
  assign reset_out_low_oe_o = !rst_out_q;
  assign wd_enabled_o = (st_q == WWD_ST_LEAD) || (st_q == WWD_ST_CLOSED) || (st_q == WWD_ST_OPEN);
endmodule : wwd_top
`default_nettype wire

//--- wwd_chk.sv
// checker: port-level properties of the window watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module wwd_chk #(
  parameter int unsigned RESET_CYC = 20,
  parameter int unsigned LEAD_N = 40,
  parameter int unsigned SHORT_N = 10,
  parameter int unsigned OPEN_FAULT_N = 20
) (
  input wire logic ref_clk_i, // clock
  input wire logic rst_n_i, // reset
  input wire logic trigger_input_low_i, // trigger
  input wire logic osc_tick_i, // timebase
  input wire logic fallback_tick_i, // fallback timebase
  input wire wwd_pkg::wwd_pin_t timing_resistor_pin_i, // pin health
  input wire logic cfg_frame_i, // frame strobe
  input wire logic watchdog_off_bit_i, // off bit
  input wire logic undervolt_i, // undervoltage
  input wire logic reset_out_low_o, // reset out
  input wire logic wd_enabled_o // supervising
);
  import wwd_pkg::*;
  logic [15:0] low_q;
  logic [15:0] fb_q;
  logic [15:0] tk_q;
  logic [1:0] ones_q;
  // ==========
  // helpers
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      low_q <= 16'h0;
      fb_q <= 16'h0;
      tk_q <= 16'h0;
      ones_q <= 2'h0;
    end else begin
      low_q <= reset_out_low_o ? 16'h0 : low_q + 16'h1;
      if (!reset_out_low_o) fb_q <= 16'h0;
      else if (fallback_tick_i && timing_resistor_pin_i != WWD_PIN_OK) fb_q <= fb_q + 16'h1;
      // trigger activity clears it, so the bound is loose but never false
      if (!reset_out_low_o || !trigger_input_low_i) tk_q <= 16'h0;
      else if (osc_tick_i) tk_q <= tk_q + 16'h1;
      if (cfg_frame_i) ones_q <= watchdog_off_bit_i ? {ones_q[0], 1'b1} : 2'h0;
    end
  end
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // ==========
  // properties
  uv_drop_a: assert property ($rose(undervolt_i) |-> ##[1:3] !reset_out_low_o)
    else $error("undervoltage left reset released");
  uv_hold_a: assert property (undervolt_i [*3] |-> !reset_out_low_o)
    else $error("reset released during undervoltage");
  pulse_len_a: assert property ($rose(reset_out_low_o) |-> low_q >= RESET_CYC)
    else $error("reset pulse too short");
  off_quiet_a: assert property (!wd_enabled_o && !$past(wd_enabled_o) && reset_out_low_o
    && !undervolt_i |=> reset_out_low_o)
    else $error("reset while watchdog off");
  off_pairs_a: assert property ($fell(wd_enabled_o) |=> !reset_out_low_o || ones_q == 2'h3)
    else $error("watchdog off without two frames");
  idle_limit_a: assert property (wd_enabled_o && timing_resistor_pin_i == WWD_PIN_OK
    |-> tk_q <= LEAD_N + 1)
    else $error("no reset after missing trigger");
  short_fault_a: assert property (wd_enabled_o && timing_resistor_pin_i == WWD_PIN_SHORT
    |-> fb_q <= SHORT_N)
    else $error("shorted pin timeout overrun");
  open_fault_a: assert property (wd_enabled_o && timing_resistor_pin_i == WWD_PIN_OPEN
    |-> fb_q <= OPEN_FAULT_N)
    else $error("open pin timeout overrun");
  cover property ($rose(undervolt_i));
  cover property ($fell(wd_enabled_o) ##1 reset_out_low_o);
  cover property ($fell(reset_out_low_o));
endmodule : wwd_chk
bind wwd_top wwd_chk #(.RESET_CYC(RESET_CYC), .LEAD_N(LEAD_N), .SHORT_N(SHORT_N),
  .OPEN_FAULT_N(OPEN_FAULT_N)) wwd_chk_i (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .trigger_input_low_i(trigger_input_low_i), .osc_tick_i(osc_tick_i),
  .fallback_tick_i(fallback_tick_i), .timing_resistor_pin_i(timing_resistor_pin_i),
  .cfg_frame_i(cfg_frame_i), .watchdog_off_bit_i(watchdog_off_bit_i),
  .undervolt_i(undervolt_i), .reset_out_low_o(reset_out_low_o), .wd_enabled_o(wd_enabled_o));
`default_nettype wire

//--- wwd_host.sv
// host model: drives the active-low trigger line
`timescale 1ns/1ps
`default_nettype none
module wwd_host (
  input wire logic clk_i, // clock
  output logic trig_low_o // trigger, idles high
);
  initial trig_low_o = 1'b1;
  // caller keeps spacing between closed max and open min
  task automatic pulse(input int len);
    @(posedge clk_i);
    trig_low_o <= 1'b0;
    repeat (len) @(posedge clk_i);
    trig_low_o <= 1'b1;
  endtask : pulse
endmodule : wwd_host
`default_nettype wire

//--- tb_window_watchdog_failsafe.sv
// testbench for the window watchdog supervisor
`timescale 1ns/1ps
`default_nettype none
module tb_window_watchdog_failsafe;
  import wwd_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, osc = 1'b0, fb = 1'b0, frm = 1'b0, obit = 1'b0, uv = 1'b0;
  logic strap = 1'b0;
  logic trig, rst_out, en, oe;
  localparam int unsigned T_RST = 20;
  localparam int unsigned T_LEAD = 40;
  localparam int unsigned T_CLOSED = 5;
  localparam int unsigned T_OPEN = 6;
  localparam int unsigned T_SHORT = 10;
  localparam int unsigned T_OPENF = 20;
  wwd_pin_t pin = WWD_PIN_OK;
  int n_mismatch = 0, num_checks = 0, cyc = 0, drops = 0, n, b;
  always #20 clk = ~clk;
  // osc tick every 100 cycles, fallback every 50
  always @(posedge clk) begin
    cyc <= cyc + 1;
    osc <= (cyc % 100 == 99);
    fb <= (cyc % 50 == 49);
    if (cyc == 40000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  always @(negedge rst_out) drops++;
  wwd_host wwd_host_i (.clk_i(clk), .trig_low_o(trig));
  wwd_top #(.RESET_CYC(T_RST), .LEAD_N(T_LEAD), .CLOSED_N(T_CLOSED), .OPEN_N(T_OPEN),
    .SHORT_N(T_SHORT), .OPEN_FAULT_N(T_OPENF)) wwd_top_i (.ref_clk_i(clk), .rst_n_i(rst_n),
    .trigger_input_low_i(trig), .osc_tick_i(osc), .fallback_tick_i(fb),
    .timing_resistor_pin_i(pin), .divider_strap_pin_i(strap), .cfg_frame_i(frm),
    .watchdog_off_bit_i(obit), .undervolt_i(uv), .reset_out_low_o(rst_out),
    .reset_out_low_oe_o(oe), .wd_enabled_o(en));
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error %0t: level %b expected %b", $time, got, exp);
    end
  endtask : chk_bit
  task automatic chk_rng(input int v, input int lo, input int hi);
    num_checks++;
    if (v < lo || v > hi) begin
      n_mismatch++;
      $display("Error %0t: count %0d outside %0d..%0d", $time, v, lo, hi);
    end
  endtask : chk_rng
  task automatic wait_lvl(input logic lvl, input int maxc, output int k);
    k = 0;
    while (rst_out !== lvl && k < maxc) begin
      @(negedge clk);
      k++;
    end
  endtask : wait_lvl
  task automatic frame_w(input logic v);
    @(posedge clk);
    frm <= 1'b1;
    obit <= v;
    @(posedge clk);
    frm <= 1'b0;
  endtask : frame_w
  task automatic s_lead;
    wait_lvl(1'b1, 200, n);
    chk_rng(n, 20, 40);
    chk_bit(oe, 1'b0);
    wait_lvl(1'b0, 4200, n);
    chk_rng(n, 3890, 4110);
    chk_bit(oe, 1'b1);
    wait_lvl(1'b1, 100, n);
    chk_rng(n, 19, 22);
  endtask : s_lead
  task automatic s_window;
    b = drops;
    wwd_host_i.pulse(200);
    for (int i = 0; i < 2; i++) begin
      repeat (600) @(posedge clk);
      wwd_host_i.pulse(200);
    end
    chk_rng(drops - b, 0, 0);
  endtask : s_window
  task automatic s_early;
    fork
      wwd_host_i.pulse(200);
      wait_lvl(1'b0, 300, n);
    join
    chk_rng(n, 176, 183);
    wait_lvl(1'b1, 100, n);
  endtask : s_early
  task automatic s_glitch_miss;
    wwd_host_i.pulse(150);
    repeat (30) @(posedge clk);
    wwd_host_i.pulse(200);
    wait_lvl(1'b0, 1300, n);
    chk_rng(n, 950, 1090);
    wait_lvl(1'b1, 100, n);
  endtask : s_glitch_miss
  task automatic s_off_uv;
    frame_w(1'b1);
    frame_w(1'b0);
    frame_w(1'b1);
    repeat (2) @(negedge clk);
    chk_bit(en, 1'b1);
    frame_w(1'b1);
    repeat (2) @(negedge clk);
    chk_bit(en, 1'b0);
    b = drops;
    repeat (5000) @(posedge clk);
    chk_rng(drops - b, 0, 0);
    frame_w(1'b0);
    @(posedge clk);
    uv <= 1'b1;
    pin <= WWD_PIN_SHORT;
    repeat (60) @(negedge clk);
    chk_bit(rst_out, 1'b0);
    @(posedge clk);
    uv <= 1'b0;
  endtask : s_off_uv
  task automatic s_fault;
    for (int i = 0; i < 2; i++) begin
      wait_lvl(1'b1, 100, n);
      wait_lvl(1'b0, 700, n);
      chk_rng(n, 440, 560);
    end
    @(posedge clk);
    pin <= WWD_PIN_OPEN;
    wait_lvl(1'b1, 100, n);
    wait_lvl(1'b0, 1300, n);
    chk_rng(n, 940, 1060);
  endtask : s_fault
  // strap high through a fresh power-on reset keeps the watchdog off
  task automatic s_strap;
    @(posedge clk);
    rst_n <= 1'b0;
    strap <= 1'b1;
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    b = drops;
    wait_lvl(1'b1, 200, n);
    chk_rng(n, 20, 40);
    repeat (2000) @(negedge clk);
    chk_bit(en, 1'b0);
    chk_rng(drops - b, 0, 0);
  endtask : s_strap
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    s_lead();
    s_window();
    s_early();
    s_glitch_miss();
    s_off_uv();
    s_fault();
    s_strap();
    tally_and_finish();
  end
endmodule : tb_window_watchdog_failsafe
`default_nettype wire
